// file: hdl/pcd_diag_gen.sv
// page-1 diagnostics registers, cable test sequencing and test packet generator
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps
// How it works
// - bit 10 enables powered device detection
// - bits 9:8 report detection outcome
// - bits 7:0 count CRC errors, clear on read
// - trigger bit stays set until test finishes
// - bit 14 flags all results valid
// - pair A/B distances in first register
// - pair C/D distances in second register
// - distance lsb equals three meters
// - four-bit termination code per pair
// - codes for ok, open, short, abnormal
// - codes 1000-1011 cross-pair short
// - codes 1100-1111 abnormal cross coupling
// - run clear stops on 10,000-packet boundary
// - fixed speed-based count or continuous
// - length field selects packet size
// - bit 10 selects short or long gap
// - destination address Fh with low nibble
// - source address Fh with low nibble
// - bit 1 selects fixed or random payload
// - bit 0 forces bad frame check sequence
// - page select gates indices 16 to 30
// - self-clearing trigger clears at test end, counter after read
// - fixed payload repeats sixteen-bit pattern
module pcd_diag_gen import pcd_pkg::*; #(
	parameter int TEST_CYCLES = 64
) (
	// clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// register port
	input wire logic [4:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	// phy core status
	input wire logic [4:0] phy_address,
	input wire logic [1:0] link_speed,
	input wire logic rx_crc_err,
	input wire logic [1:0] pd_detect_status,
	// cable measurement results
	input wire logic [23:0] meas_dist,
	input wire logic [15:0] meas_term,
	// cable measurement control
	output logic tdr_start,
	output logic pd_detect_en,
	// generated byte stream
	input wire logic tx_byte_en,
	output logic [7:0] tx_data,
	output logic tx_valid
);
	if (TEST_CYCLES < 1 || TEST_CYCLES > 998) begin : g_bad_cycles
		$error("TEST_CYCLES out of range");
	end

	// ----------------------------------------
	// register decode
	// ----------------------------------------
	logic [15:0] page_q;
	logic ext_hit;
	assign ext_hit = (page_q == PCD_PAGE_ONE) && (reg_addr >= PCD_IDX_EXT_LO)
		&& (reg_addr != PCD_IDX_PAGE);
	logic wr_gen1, wr_gen2, wr_ctrl4, wr_diag1, rd_ctrl4;
	assign wr_gen1 = reg_wr && ext_hit && reg_addr == PCD_IDX_GEN1;
	assign wr_gen2 = reg_wr && ext_hit && reg_addr == PCD_IDX_GEN2;
	assign wr_ctrl4 = reg_wr && ext_hit && reg_addr == PCD_IDX_CTRL4;
	assign wr_diag1 = reg_wr && ext_hit && reg_addr == PCD_IDX_DIAG1;
	assign rd_ctrl4 = reg_rd && ext_hit && reg_addr == PCD_IDX_CTRL4;

	always_ff @(posedge clock) begin
		if (!rst_n) page_q <= '0;
		else if (reg_wr && reg_addr == PCD_IDX_PAGE) page_q <= reg_wdata;
	end

	// ----------------------------------------
	// control 4: detection and crc errors
	// ----------------------------------------
	logic [7:0] crc_cnt_q;
	always_ff @(posedge clock) begin
		if (!rst_n) pd_detect_en <= 1'b0;
		else if (wr_ctrl4) pd_detect_en <= reg_wdata[PCD_B_PD_EN];
	end
	always_ff @(posedge clock) begin
		if (!rst_n) crc_cnt_q <= '0;
		else if (rx_crc_err) crc_cnt_q <= rd_ctrl4 ? 8'h01 : crc_cnt_q + 8'h01;
		else if (rd_ctrl4) crc_cnt_q <= '0;
	end

	// ----------------------------------------
	// cable test sequencing
	// ----------------------------------------
	pcd_tdr_e tdr_q;
	logic trig_q, valid_q;
	logic [15:0] tcnt_q;
	logic [23:0] dist_q;
	logic [15:0] term_q;
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			tdr_q <= PCD_T_IDLE;
			trig_q <= 1'b0;
			valid_q <= 1'b0;
			tcnt_q <= '0;
			tdr_start <= 1'b0;
			dist_q <= '0;
			term_q <= '0;
		end else begin
			tdr_start <= 1'b0;
			case (tdr_q)
				PCD_T_IDLE: begin
					if (wr_diag1 && reg_wdata[PCD_B_TRIG]) begin
						trig_q <= 1'b1;
						valid_q <= 1'b0;
						tdr_start <= 1'b1;
						tcnt_q <= '0;
						tdr_q <= PCD_T_RUN;
					end
				end
				PCD_T_RUN: begin
					tcnt_q <= tcnt_q + 16'h0001;
					if (tcnt_q == 16'(TEST_CYCLES - 1)) begin
						dist_q <= meas_dist;
						term_q <= meas_term;
						trig_q <= 1'b0;
						tdr_q <= PCD_T_DONE;
					end
				end
				PCD_T_DONE: begin
					valid_q <= 1'b1;
					tdr_q <= PCD_T_IDLE;
				end
				default: tdr_q <= PCD_T_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// generator control
	// ----------------------------------------
	logic [15:0] gen1_q, pattern_q;
	always_ff @(posedge clock) begin
		if (!rst_n) gen1_q <= PCD_GEN1_RST;
		else if (wr_gen1) gen1_q <= reg_wdata & PCD_GEN1_WMASK;
	end
	always_ff @(posedge clock) begin
		if (!rst_n) pattern_q <= '0;
		else if (wr_gen2) pattern_q <= reg_wdata;
	end

	// ----------------------------------------
	// read mux
	// ----------------------------------------
	always_ff @(posedge clock) begin
		if (!rst_n) reg_rdata <= '0;
		else if (reg_rd) begin
			reg_rdata <= '0;
			if (reg_addr == PCD_IDX_PAGE) reg_rdata <= page_q;
			else if (ext_hit) begin
				case (reg_addr)
					PCD_IDX_CTRL4: reg_rdata <= {phy_address, pd_detect_en,
						pd_detect_status, crc_cnt_q};
					PCD_IDX_DIAG1: reg_rdata <= {trig_q, valid_q, dist_q[23:18],
						2'h0, dist_q[17:12]};
					PCD_IDX_DIAG2: reg_rdata <= {2'h0, dist_q[11:6], 2'h0,
						dist_q[5:0]};
					PCD_IDX_TERM: reg_rdata <= term_q;
					PCD_IDX_GEN1: reg_rdata <= gen1_q;
					PCD_IDX_GEN2: reg_rdata <= pattern_q;
					default: reg_rdata <= '0;
				endcase
			end
		end
	end

	// ----------------------------------------
	// packet generator
	// ----------------------------------------
	pcd_gen_e gst_q;
	logic [13:0] bcnt_q, blk_q;
	logic [31:0] pkts_q, crc_q, target;
	logic [15:0] lfsr_q;
	logic [13:0] plen, paylen, gaplen;
	logic [7:0] nxt_byte;
	logic [31:0] crc_nx;
	logic blk_end, stop_now;

	always_comb begin
		case (gen1_q[12:11])
			2'h0: plen = PCD_LEN_125;
			2'h1: plen = PCD_LEN_64;
			2'h2: plen = PCD_LEN_1518;
			default: plen = PCD_LEN_JUMBO;
		endcase
		paylen = plen - PCD_HDR_BYTES - PCD_FCS_BYTES;
		gaplen = gen1_q[PCD_B_GAP] ? PCD_GAP_LONG : PCD_GAP_SHORT;
		case (link_speed)
			PCD_SPD_10: target = PCD_CNT_10;
			PCD_SPD_100: target = PCD_CNT_100;
			default: target = PCD_CNT_1000;
		endcase
	end

	always_comb begin
		nxt_byte = PCD_ADDR_HI;
		case (gst_q)
			PCD_DA: nxt_byte = (bcnt_q == 14'h0005) ? {PCD_NIB_HI, gen1_q[9:6]}
				: PCD_ADDR_HI;
			PCD_SA: nxt_byte = (bcnt_q == 14'h0005) ? {PCD_NIB_HI, gen1_q[5:2]}
				: PCD_ADDR_HI;
			PCD_LT: nxt_byte = bcnt_q[0] ? paylen[7:0] : {2'h0, paylen[13:8]};
			PCD_PAY: nxt_byte = gen1_q[PCD_B_RAND] ? lfsr_q[7:0]
				: (bcnt_q[0] ? pattern_q[7:0] : pattern_q[15:8]);
			default: nxt_byte = PCD_ADDR_HI;
		endcase
		crc_nx = crc_q ^ {24'h0, nxt_byte};
		for (int i = 0; i < 8; i++) begin
			crc_nx = crc_nx[0] ? ((crc_nx >> 1) ^ PCD_CRC_POLY) : (crc_nx >> 1);
		end
	end

	assign blk_end = (blk_q == PCD_BLOCK_PKTS - 14'h0001);
	assign stop_now = !gen1_q[PCD_B_GEN_EN]
		|| (!gen1_q[PCD_B_RUN] && blk_end)
		|| (!gen1_q[PCD_B_CONT] && pkts_q == target - 32'h1);

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			gst_q <= PCD_IDLE;
			bcnt_q <= '0;
			blk_q <= '0;
			pkts_q <= '0;
			crc_q <= PCD_CRC_INIT;
			lfsr_q <= PCD_LFSR_SEED;
			tx_data <= '0;
			tx_valid <= 1'b0;
		end else if (tx_byte_en) begin
			tx_valid <= 1'b0;
			bcnt_q <= bcnt_q + 14'h0001;
			case (gst_q)
				PCD_IDLE: begin
					bcnt_q <= '0;
					crc_q <= PCD_CRC_INIT;
					if (gen1_q[PCD_B_GEN_EN] && gen1_q[PCD_B_RUN]) gst_q <= PCD_DA;
				end
				PCD_DA, PCD_SA, PCD_LT, PCD_PAY: begin
					tx_data <= nxt_byte;
					tx_valid <= 1'b1;
					crc_q <= crc_nx;
					if (gst_q == PCD_PAY) lfsr_q <= {lfsr_q[14:0],
						lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
					if ((gst_q == PCD_LT && bcnt_q == 14'h0001)
						|| (gst_q == PCD_PAY && bcnt_q == paylen - 14'h0001)
						|| (gst_q != PCD_LT && gst_q != PCD_PAY && bcnt_q == 14'h0005)) begin
						bcnt_q <= '0;
						case (gst_q)
							PCD_DA: gst_q <= PCD_SA;
							PCD_SA: gst_q <= PCD_LT;
							PCD_LT: gst_q <= PCD_PAY;
							default: gst_q <= PCD_FCS;
						endcase
					end
				end
				PCD_FCS: begin
					tx_data <= ~crc_q[8*bcnt_q[1:0] +: 8]
						^ {7'h0, gen1_q[PCD_B_BADFCS]};
					tx_valid <= 1'b1;
					if (bcnt_q == PCD_FCS_BYTES - 14'h0001) begin
						bcnt_q <= '0;
						gst_q <= PCD_GAPS;
					end
				end
				PCD_GAPS: begin
					if (bcnt_q == gaplen - 14'h0001) begin
						bcnt_q <= '0;
						crc_q <= PCD_CRC_INIT;
						blk_q <= blk_end ? '0 : blk_q + 14'h0001;
						pkts_q <= pkts_q + 32'h1;
						if (stop_now) begin
							gst_q <= PCD_IDLE;
							pkts_q <= '0;
							blk_q <= '0;
						end else gst_q <= PCD_DA;
					end
				end
				default: gst_q <= PCD_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	property p_trig_clears;
		@(posedge clock) disable iff (!rst_n)
			$rose(trig_q) |-> ##[1:1000] !trig_q;
	endproperty
	a_trig_clears: assert property (p_trig_clears) else $error("trigger stuck");
	property p_valid_low_running;
		@(posedge clock) disable iff (!rst_n) trig_q |-> !valid_q;
	endproperty
	a_valid_low_running: assert property (p_valid_low_running)
		else $error("valid during test");
	property p_valid_after;
		@(posedge clock) disable iff (!rst_n) $fell(trig_q) |=> valid_q;
	endproperty
	a_valid_after: assert property (p_valid_after) else $error("valid missing");
	property p_crc_clear;
		@(posedge clock) disable iff (!rst_n) rd_ctrl4 && !rx_crc_err |=> crc_cnt_q == 8'h00;
	endproperty
	a_crc_clear: assert property (p_crc_clear) else $error("counter not cleared");
	property p_crc_count;
		@(posedge clock) disable iff (!rst_n)
			rx_crc_err && !rd_ctrl4 |=> crc_cnt_q == $past(crc_cnt_q) + 8'h01;
	endproperty
	a_crc_count: assert property (p_crc_count) else $error("counter missed");
	property p_pd_en;
		@(posedge clock) disable iff (!rst_n)
			wr_ctrl4 |=> pd_detect_en == $past(reg_wdata[PCD_B_PD_EN]);
	endproperty
	a_pd_en: assert property (p_pd_en) else $error("detect enable wrong");
	property p_page_gate;
		@(posedge clock) disable iff (!rst_n)
			reg_rd && page_q != PCD_PAGE_ONE && reg_addr != PCD_IDX_PAGE |=> reg_rdata == 16'h0;
	endproperty
	a_page_gate: assert property (p_page_gate) else $error("page not gated");
	property p_stop_block;
		@(posedge clock) disable iff (!rst_n)
			gst_q == PCD_GAPS && tx_byte_en && bcnt_q == gaplen - 14'h0001 && gen1_q[PCD_B_GEN_EN]
			&& gen1_q[PCD_B_CONT] && !blk_end |=> gst_q == PCD_DA;
	endproperty
	a_stop_block: assert property (p_stop_block) else $error("stopped mid block");
	property p_launch_clears_valid;
		@(posedge clock) disable iff (!rst_n) tdr_start |-> trig_q && !valid_q;
	endproperty
	a_launch_clears_valid: assert property (p_launch_clears_valid)
		else $error("valid kept at launch");
	c_test_done: cover property (@(posedge clock) disable iff (!rst_n) $fell(trig_q));
	c_pkt_sent: cover property (@(posedge clock) disable iff (!rst_n) gst_q == PCD_GAPS);
	c_crc_rd: cover property (@(posedge clock) disable iff (!rst_n) rd_ctrl4 && rx_crc_err);
	c_bad_fcs: cover property (@(posedge clock) disable iff (!rst_n)
		gst_q == PCD_FCS && gen1_q[PCD_B_BADFCS]);
endmodule

// file: hdl/pcd_pkg.sv
// constants for the page-1 diagnostics and packet generator block
package pcd_pkg;
	// ----------------------------------------
	// register indices
	// ----------------------------------------
	localparam logic [4:0] PCD_IDX_CTRL4 = 5'h17;
	localparam logic [4:0] PCD_IDX_DIAG1 = 5'h18;
	localparam logic [4:0] PCD_IDX_DIAG2 = 5'h19;
	localparam logic [4:0] PCD_IDX_TERM = 5'h1a;
	localparam logic [4:0] PCD_IDX_GEN1 = 5'h1d;
	localparam logic [4:0] PCD_IDX_GEN2 = 5'h1e;
	localparam logic [4:0] PCD_IDX_PAGE = 5'h1f;
	localparam logic [4:0] PCD_IDX_EXT_LO = 5'h10;
	localparam logic [15:0] PCD_PAGE_ONE = 16'h0001;
	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int PCD_B_PD_EN = 10;
	localparam int PCD_B_TRIG = 15;
	localparam int PCD_B_VALID = 14;
	localparam int PCD_B_GEN_EN = 15;
	localparam int PCD_B_RUN = 14;
	localparam int PCD_B_CONT = 13;
	localparam int PCD_B_GAP = 10;
	localparam int PCD_B_RAND = 1;
	localparam int PCD_B_BADFCS = 0;
	localparam logic [15:0] PCD_GEN1_RST = 16'h0040;
	localparam logic [15:0] PCD_GEN1_WMASK = 16'hfffe | 16'h0001;
	// ----------------------------------------
	// termination codes
	// ----------------------------------------
	localparam logic [3:0] PCD_TERM_OK = 4'h0;
	localparam logic [3:0] PCD_TERM_OPEN = 4'h1;
	localparam logic [3:0] PCD_TERM_SHORT = 4'h2;
	localparam logic [3:0] PCD_TERM_ABN = 4'h4;
	localparam logic [3:0] PCD_TERM_XSHORT = 4'h8;
	localparam logic [3:0] PCD_TERM_XCPL = 4'hc;
	// ----------------------------------------
	// generator figures
	// ----------------------------------------
	localparam int PCD_DIST_M_PER_LSB = 3;
	localparam logic [13:0] PCD_LEN_125 = 14'h007d;
	localparam logic [13:0] PCD_LEN_64 = 14'h0040;
	localparam logic [13:0] PCD_LEN_1518 = 14'h05ee;
	localparam logic [13:0] PCD_LEN_JUMBO = 14'h2710;
	localparam logic [13:0] PCD_GAP_SHORT = 14'h000c;
	localparam logic [13:0] PCD_GAP_LONG = 14'h0400;
	localparam logic [13:0] PCD_HDR_BYTES = 14'h000e;
	localparam logic [13:0] PCD_FCS_BYTES = 14'h0004;
	localparam logic [13:0] PCD_BLOCK_PKTS = 14'h2710;
	localparam logic [31:0] PCD_CNT_1000 = 32'h01c9c380;
	localparam logic [31:0] PCD_CNT_100 = 32'h002dc6c0;
	localparam logic [31:0] PCD_CNT_10 = 32'h000493e0;
	localparam logic [1:0] PCD_SPD_10 = 2'h0;
	localparam logic [1:0] PCD_SPD_100 = 2'h1;
	localparam logic [31:0] PCD_CRC_INIT = 32'hffffffff;
	localparam logic [31:0] PCD_CRC_POLY = 32'hedb88320;
	localparam logic [15:0] PCD_LFSR_SEED = 16'hace1;
	localparam logic [7:0] PCD_ADDR_HI = 8'hff;
	localparam logic [3:0] PCD_NIB_HI = 4'hf;
	typedef enum logic [2:0] {PCD_IDLE, PCD_DA, PCD_SA, PCD_LT, PCD_PAY, PCD_FCS, PCD_GAPS}
		pcd_gen_e;
	typedef enum logic [1:0] {PCD_T_IDLE, PCD_T_RUN, PCD_T_DONE} pcd_tdr_e;
endpackage

// file: verification/pcd_cable_model.sv
// cable and link partner model for the diagnostics block
`timescale 1ns/1ps
module pcd_cable_model (
	// clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// cable setup from bench
	input wire logic [23:0] set_dist,
	input wire logic [15:0] set_term,
	// block side
	input wire logic tdr_start,
	input wire logic pd_detect_en,
	output logic [23:0] meas_dist,
	output logic [15:0] meas_term,
	output logic [1:0] pd_detect_status,
	output logic tx_byte_en
);
	logic [7:0] hold_q;
	logic [1:0] pace_q;
	// ----------------------------------------
	// results stand for a while after launch
	// ----------------------------------------
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			hold_q <= 8'h00;
		end else if (tdr_start) begin
			hold_q <= 8'h40;
		end else if (hold_q != 8'h00) begin
			hold_q <= hold_q - 8'h01;
		end
	end
	// scrambled outside the measurement span
	assign meas_dist = (hold_q != 8'h00) ? set_dist : ~set_dist;
	assign meas_term = (hold_q != 8'h00) ? set_term : ~set_term;
	// powered device answers only while detection enabled
	assign pd_detect_status = pd_detect_en ? 2'h2 : 2'h0;
	// ----------------------------------------
	// byte pacing, stall every fourth cycle
	// ----------------------------------------
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			pace_q <= 2'h0;
		end else begin
			pace_q <= pace_q + 2'h1;
		end
	end
	assign tx_byte_en = (pace_q != 2'h3);
endmodule

// file: verification/pcd_diag_gen_tb.sv
// self-checking bench for the diagnostics and packet generator block
`timescale 1ns/1ps
module pcd_diag_gen_tb import pcd_pkg::*;;
	localparam int TC = 4;
	logic clock, rst_n, reg_wr, reg_rd, rx_crc_err, tdr_start, pd_detect_en;
	logic tx_byte_en, tx_valid;
	logic [4:0] reg_addr;
	logic [15:0] reg_wdata, reg_rdata, rv, set_term, meas_term;
	logic [23:0] set_dist, meas_dist;
	logic [1:0] pd_detect_status;
	logic [7:0] tx_data;
	logic [7:0] q[$];
	int qi[$];
	int err_count = 0;
	int n_checks = 0;
	int n_start = 0;
	int bidx = 0;
	logic [23:0] dtab [3] = '{24'hfc156a, 24'h020f87, 24'ha9507f};
	logic [15:0] ttab [3] = '{16'h0124, 16'h89ab, 16'hcdef};

	pcd_diag_gen #(.TEST_CYCLES(TC)) i_dut (.clock(clock), .rst_n(rst_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .phy_address(5'h0a), .link_speed(2'h2),
		.rx_crc_err(rx_crc_err), .pd_detect_status(pd_detect_status),
		.meas_dist(meas_dist), .meas_term(meas_term), .tdr_start(tdr_start),
		.pd_detect_en(pd_detect_en), .tx_byte_en(tx_byte_en), .tx_data(tx_data),
		.tx_valid(tx_valid));
	pcd_cable_model i_model (.clock(clock), .rst_n(rst_n), .set_dist(set_dist),
		.set_term(set_term), .tdr_start(tdr_start), .pd_detect_en(pd_detect_en),
		.meas_dist(meas_dist), .meas_term(meas_term),
		.pd_detect_status(pd_detect_status), .tx_byte_en(tx_byte_en));

	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end
	// ----------------------------------------
	// stream capture
	// ----------------------------------------
	always @(posedge clock) begin
		if (tx_byte_en) bidx = bidx + 1;
		if (tx_byte_en && tx_valid) begin
			q.push_back(tx_data);
			qi.push_back(bidx);
		end
		if (tdr_start) n_start = n_start + 1;
	end
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task wrap_up;
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask
	task rd(input logic [4:0] a);
		@(posedge clock);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1 rv = reg_rdata;
	endtask
	task rst_seq;
		rst_n <= 1'b0;
		repeat (8) @(posedge clock);
		rst_n <= 1'b1;
		q.delete();
		qi.delete();
	endtask
	task pkt(input int len, input logic [3:0] da, input logic [3:0] sa, input int gap,
		input logic bad, input logic fixed);
		logic [31:0] c;
		logic ok;
		for (int w = 0; w < 5000 && q.size() < len + 1; w++) @(posedge clock);
		ok = 1'b1;
		for (int i = 0; i < 12; i++)
			if (q[i] !== ((i == 5) ? {4'hf, da} : (i == 11) ? {4'hf, sa} : 8'hff)) ok = 1'b0;
		chk("addresses", {15'h0, ok}, 16'h0001);
		chk("length type", {q[12], q[13]}, 16'(len - 18));
		ok = 1'b1;
		for (int i = 14; i < len - 4; i++)
			if (q[i] !== (((i - 14) % 2 == 0) ? 8'ha5 : 8'h3c)) ok = 1'b0;
		chk("payload kind", {15'h0, ok}, {15'h0, fixed});
		c = PCD_CRC_INIT;
		for (int i = 0; i < len - 4; i++) begin
			c = c ^ {24'h0, q[i]};
			for (int b = 0; b < 8; b++) c = c[0] ? ((c >> 1) ^ PCD_CRC_POLY) : (c >> 1);
		end
		c = ~c ^ {4{7'h0, bad}};
		chk("fcs low", {q[len - 3], q[len - 4]}, c[15:0]);
		chk("fcs high", {q[len - 1], q[len - 2]}, c[31:16]);
		chk("gap", 16'(qi[len] - qi[len - 1] - 1), 16'(gap));
		chk("next start", {8'h00, q[len]}, 16'h00ff);
	endtask
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		rst_n = 1'b0;
		reg_addr = 5'h00;
		reg_wdata = 16'h0000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		rx_crc_err = 1'b0;
		set_dist = 24'h000000;
		set_term = 16'h0000;
		rst_seq;
		rd(PCD_IDX_GEN1);
		chk("gen1 unpaged", rv, 16'h0000);
		wr(PCD_IDX_PAGE, PCD_PAGE_ONE);
		rd(PCD_IDX_CTRL4);
		chk("ctrl4 reset", rv, 16'h5000);
		rd(PCD_IDX_GEN1);
		chk("gen1 reset", rv, PCD_GEN1_RST);
		wr(PCD_IDX_CTRL4, 16'hffff);
		rd(PCD_IDX_CTRL4);
		chk("ctrl4 detect", rv, 16'h5600);
		repeat (3) begin
			@(posedge clock);
			rx_crc_err <= 1'b1;
			@(posedge clock);
			rx_crc_err <= 1'b0;
		end
		rd(PCD_IDX_CTRL4);
		chk("crc count", rv, 16'h5603);
		rd(PCD_IDX_CTRL4);
		chk("crc cleared", rv, 16'h5600);
		for (int k = 0; k < 3; k++) begin
			set_dist <= dtab[k];
			set_term <= ttab[k];
			wr(PCD_IDX_DIAG1, 16'h8000);
			rd(PCD_IDX_DIAG1);
			chk("diag running", {14'h0, rv[15:14]}, 16'h0002);
			repeat (TC + 4) @(posedge clock);
			rd(PCD_IDX_DIAG1);
			chk("diag1", rv, {2'b01, dtab[k][23:18], 2'b00, dtab[k][17:12]});
			rd(PCD_IDX_DIAG2);
			chk("diag2", rv, {2'b00, dtab[k][11:6], 2'b00, dtab[k][5:0]});
			rd(PCD_IDX_TERM);
			chk("term", rv, ttab[k]);
			chk("launches", 16'(n_start), 16'(k + 1));
		end
		wr(PCD_IDX_TERM, 16'h0000);
		rd(PCD_IDX_TERM);
		chk("term read only", rv, ttab[2]);
		wr(PCD_IDX_GEN2, 16'ha53c);
		wr(PCD_IDX_GEN1, 16'he8d4);
		rd(PCD_IDX_GEN1);
		chk("gen1 rw", rv, 16'he8d4);
		pkt(64, 4'h3, 4'h5, 12, 1'b0, 1'b1);
		rst_seq;
		rd(PCD_IDX_GEN1);
		chk("page after reset", rv, 16'h0000);
		wr(PCD_IDX_PAGE, PCD_PAGE_ONE);
		wr(PCD_IDX_GEN1, 16'he7c3);
		pkt(125, 4'hf, 4'h0, 1024, 1'b1, 1'b0);
		rst_seq;
		wr(PCD_IDX_PAGE, PCD_PAGE_ONE);
		wr(PCD_IDX_GEN2, 16'ha53c);
		wr(PCD_IDX_GEN1, 16'hf0a4);
		pkt(1518, 4'h2, 4'h9, 12, 1'b0, 1'b1);
		wrap_up;
	end
	// ----------------------------------------
	// watchdog
	// ----------------------------------------
	initial begin
		repeat (20000) @(posedge clock);
		err_count++;
		wrap_up;
	end
endmodule
